/* logic/acsdp_clkgen.sv */
// Master bit clock divider and word clock generator
`timescale 1ns/1ps
`default_nettype none
module acsdp_clkgen #(
  parameter int BCLK_HALF = 2
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic       launch_lvl_i,
  input  wire logic       pulse_i,
  input  wire logic [8:0] frame_len_i,
  // Generated clocks
  output logic            bclk_o,
  output logic            wclk_o
);
  localparam int DW = (BCLK_HALF > 1) ? $clog2(BCLK_HALF) : 1;

  logic [DW-1:0] div_reg;
  logic [8:0]    pos_reg;
  logic          bclk_reg;
  logic          wclk_reg;
  wire           tick    = (div_reg == DW'(BCLK_HALF - 1));
  wire           advance = tick & (~bclk_reg == launch_lvl_i);
  wire  [8:0]    pos_inc = pos_reg + 9'h001;
  wire  [8:0]    pos_new = (pos_inc >= frame_len_i) ? 9'h000 : pos_inc;
  wire           wclk_new = pulse_i ? (pos_new == 9'h000) : (pos_new < (frame_len_i >> 1));

  assign bclk_o = bclk_reg;
  assign wclk_o = wclk_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i | ~run_i)
    begin
      // Park so that the first launch edge after restart opens a frame
      div_reg  <= '0;
      pos_reg  <= 9'h1ff;
      bclk_reg <= 1'b0;
      wclk_reg <= 1'b0;
    end
    else
    begin
      div_reg  <= tick ? '0 : div_reg + 1'b1;
      bclk_reg <= tick ? ~bclk_reg : bclk_reg;
      pos_reg  <= advance ? pos_new : pos_reg;
      wclk_reg <= advance ? wclk_new : wclk_reg;
    end
  end
endmodule
`default_nettype wire

/* logic/acsdp_fifo.sv */
// Sample FIFO, parameterised in width and depth
`timescale 1ns/1ps
`default_nettype none
module acsdp_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  acsdp_stream_if.src           out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             room_reg;
  wire              push = in_valid_i & room_reg;
  wire              pop  = out.ready & (count_reg != '0);

  assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready_o = room_reg;
  assign out.valid  = (count_reg != '0);
  assign out.data   = mem_reg[rd_ptr_reg];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      room_reg   <= 1'b1;
    end
    else
    begin
      wr_ptr_reg <= push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
      rd_ptr_reg <= pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
      count_reg  <= count_next;
      room_reg   <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

/* logic/acsdp_pkg.sv */
// Shared constants, field positions and types of the audio serial data port
package acsdp_pkg;

  // Register offsets and reset value
  localparam logic [7:0] ACSDP_FMT_ADDR  = 8'h1b;
  localparam logic [7:0] ACSDP_OFF1_ADDR = 8'h1c;
  localparam logic [7:0] ACSDP_POL_ADDR  = 8'h1d;
  localparam logic [7:0] ACSDP_DIV_ADDR  = 8'h1e;
  localparam logic [7:0] ACSDP_OFF2_ADDR = 8'h25;
  localparam logic [7:0] ACSDP_SLOT_ADDR = 8'h26;
  localparam logic [7:0] ACSDP_REG_RST   = 8'h00;

  // Format and width control fields
  localparam int ACSDP_FMT_LO   = 6;
  localparam int ACSDP_WID_LO   = 4;
  localparam int ACSDP_BMST_BIT = 3;
  localparam int ACSDP_WMST_BIT = 2;
  localparam int ACSDP_TRI_BIT  = 0;

  // Clock polarity control fields
  localparam int ACSDP_INV_BIT   = 3;
  localparam int ACSDP_KEEP_BIT  = 2;
  localparam int ACSDP_HOST_BIT  = 1;
  localparam int ACSDP_PULSE_BIT = 0;

  // Slot and channel control fields
  localparam int ACSDP_SWAP_BIT  = 4;
  localparam int ACSDP_DIS2_BIT  = 3;
  localparam int ACSDP_DIS1_BIT  = 2;
  localparam int ACSDP_EARLY_BIT = 1;
  localparam int ACSDP_TS_BIT    = 0;

  // Sizes
  localparam int ACSDP_SMP_W   = 32;
  localparam int ACSDP_CNT_W   = 10;
  localparam int ACSDP_LEN_W   = 9;
  localparam int ACSDP_HOSTS   = 2;
  localparam int ACSDP_FIFO_D  = 4;
  localparam logic [8:0] ACSDP_LEN_ZERO = 9'h100;

  typedef enum logic [1:0] {
    ACSDP_I2S          = 2'b00,
    ACSDP_DSP          = 2'b01,
    ACSDP_RJF          = 2'b10,
    ACSDP_LEFT_ALIGNED = 2'b11
  } acsdp_fmt_type;

  function automatic logic [5:0] acsdp_width(input logic [1:0] code);
    case (code)
      2'b00:   acsdp_width = 6'h10;
      2'b01:   acsdp_width = 6'h14;
      2'b10:   acsdp_width = 6'h18;
      default: acsdp_width = 6'h20;
    endcase
  endfunction

endpackage

/* logic/acsdp_stream_if.sv */
// Valid/ready sample stream between the FIFO and the serialiser
`timescale 1ns/1ps
`default_nettype none
interface acsdp_stream_if #(parameter int WIDTH = 64);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* logic/acsdp_top.sv */
// Audio serial data port: registers, framing, serialiser and pin drive
`timescale 1ns/1ps
`default_nettype none
module acsdp_top
  import acsdp_pkg::*;
#(
  parameter int BCLK_HALF = 2
) (
  // Clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_i,
  // Register port
  input  wire logic                                reg_wr_i,
  input  wire logic [7:0]                          reg_addr_i,
  input  wire logic [7:0]                          reg_wdata_i,
  output logic      [7:0]                          reg_rdata_o,
  // Power state
  input  wire logic                                port_power_i,
  input  wire logic                                adc_power_i,
  // Sample stream from the converter
  input  wire logic                                smp_valid_i,
  output logic                                     smp_ready_o,
  input  wire logic [acsdp_pkg::ACSDP_SMP_W-1:0]   smp_left_i,
  input  wire logic [acsdp_pkg::ACSDP_SMP_W-1:0]   smp_right_i,
  // Serial pins, one set per host
  input  wire logic [acsdp_pkg::ACSDP_HOSTS-1:0]   bclk_i,
  output logic      [acsdp_pkg::ACSDP_HOSTS-1:0]   bclk_o,
  output logic      [acsdp_pkg::ACSDP_HOSTS-1:0]   bclk_oe_o,
  input  wire logic [acsdp_pkg::ACSDP_HOSTS-1:0]   wclk_i,
  output logic      [acsdp_pkg::ACSDP_HOSTS-1:0]   wclk_o,
  output logic      [acsdp_pkg::ACSDP_HOSTS-1:0]   wclk_oe_o,
  output logic      [acsdp_pkg::ACSDP_HOSTS-1:0]   dout_o,
  output logic      [acsdp_pkg::ACSDP_HOSTS-1:0]   dout_oe_o,
  // Filter sync
  output logic                                     filter_sync_o
);
  import acsdp_pkg::*;

  localparam int CW = ACSDP_CNT_W;
  localparam int SW = ACSDP_SMP_W;
  localparam int HB = (ACSDP_HOSTS > 1) ? $clog2(ACSDP_HOSTS) : 1;

  // Configuration registers
  logic [7:0] fmt_reg;
  logic [7:0] off1_reg;
  logic [7:0] pol_reg;
  logic [7:0] div_reg;
  logic [7:0] off2_reg;
  logic [7:0] slot_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      fmt_reg  <= ACSDP_REG_RST;
      off1_reg <= ACSDP_REG_RST;
      pol_reg  <= ACSDP_REG_RST;
      div_reg  <= ACSDP_REG_RST;
      off2_reg <= ACSDP_REG_RST;
      slot_reg <= ACSDP_REG_RST;
    end
    else if (reg_wr_i)
    begin
      fmt_reg  <= (reg_addr_i == ACSDP_FMT_ADDR)  ? reg_wdata_i : fmt_reg;
      off1_reg <= (reg_addr_i == ACSDP_OFF1_ADDR) ? reg_wdata_i : off1_reg;
      pol_reg  <= (reg_addr_i == ACSDP_POL_ADDR)  ? reg_wdata_i : pol_reg;
      div_reg  <= (reg_addr_i == ACSDP_DIV_ADDR)  ? reg_wdata_i : div_reg;
      off2_reg <= (reg_addr_i == ACSDP_OFF2_ADDR) ? reg_wdata_i : off2_reg;
      slot_reg <= (reg_addr_i == ACSDP_SLOT_ADDR) ? reg_wdata_i : slot_reg;
    end
  end

  // Unmapped offsets read as zero
  assign rdata_next = (reg_addr_i == ACSDP_FMT_ADDR)  ? fmt_reg  :
                      (reg_addr_i == ACSDP_OFF1_ADDR) ? off1_reg :
                      (reg_addr_i == ACSDP_POL_ADDR)  ? pol_reg  :
                      (reg_addr_i == ACSDP_DIV_ADDR)  ? div_reg  :
                      (reg_addr_i == ACSDP_OFF2_ADDR) ? off2_reg :
                      (reg_addr_i == ACSDP_SLOT_ADDR) ? slot_reg : ACSDP_REG_RST;

  always_ff @(posedge mclk_i)
  begin
    rdata_reg <= rst_i ? ACSDP_REG_RST : rdata_next;
  end
  assign reg_rdata_o = rdata_reg;

  // Decoded fields
  acsdp_fmt_type fmt;
  assign fmt = acsdp_fmt_type'(fmt_reg[ACSDP_FMT_LO +: 2]);
  wire [5:0] width    = acsdp_width(fmt_reg[ACSDP_WID_LO +: 2]);
  wire       bclk_mst = fmt_reg[ACSDP_BMST_BIT];
  wire       wclk_mst = fmt_reg[ACSDP_WMST_BIT];
  wire       tri_en   = fmt_reg[ACSDP_TRI_BIT];
  wire       invert   = pol_reg[ACSDP_INV_BIT];
  wire       keep_clk = pol_reg[ACSDP_KEEP_BIT];
  wire       host_sel = pol_reg[ACSDP_HOST_BIT];
  wire       pulse_wc = pol_reg[ACSDP_PULSE_BIT];
  wire       is_rjf   = (fmt == ACSDP_RJF);
  wire       is_i2s   = (fmt == ACSDP_I2S);
  wire       is_dsp   = (fmt == ACSDP_DSP);
  wire       swap     = slot_reg[ACSDP_SWAP_BIT];
  wire       early    = slot_reg[ACSDP_EARLY_BIT];
  wire       tslot    = slot_reg[ACSDP_TS_BIT] & ~is_rjf;
  wire       en_a     = is_rjf | ~slot_reg[ACSDP_DIS1_BIT];
  wire       en_b     = is_rjf | ~slot_reg[ACSDP_DIS2_BIT];
  wire       frame_md = is_dsp | tslot;
  wire [8:0] frame_len = (div_reg == 8'h00) ? ACSDP_LEN_ZERO : {1'b0, div_reg};

  // Data launches on the edge opposite the one the host samples on
  wire       launch_lvl = invert ^ is_dsp;
  wire       clk_run    = port_power_i & (adc_power_i | keep_clk);

  logic gen_bclk;
  logic gen_wclk;

  acsdp_clkgen #(
    .BCLK_HALF (BCLK_HALF)
  ) u_clkgen (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .run_i        (clk_run),
    .launch_lvl_i (launch_lvl),
    .pulse_i      (pulse_wc),
    .frame_len_i  (frame_len),
    .bclk_o       (gen_bclk),
    .wclk_o       (gen_wclk)
  );

  // Pin synchronisers for slave clocks of the selected host
  logic [2:0] bsync_reg;
  logic [2:0] wsync_reg;
  logic       bstable_reg;
  logic       wstable_reg;
  wire  [HB-1:0] hidx = HB'(host_sel);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bsync_reg   <= 3'h0;
      wsync_reg   <= 3'h0;
      bstable_reg <= 1'b0;
      wstable_reg <= 1'b0;
    end
    else
    begin
      bsync_reg   <= {bsync_reg[1:0], bclk_i[hidx]};
      wsync_reg   <= {wsync_reg[1:0], wclk_i[hidx]};
      bstable_reg <= (bsync_reg[1] == bsync_reg[2]) ? bsync_reg[2] : bstable_reg;
      wstable_reg <= (wsync_reg[1] == wsync_reg[2]) ? wsync_reg[2] : wstable_reg;
    end
  end

  wire bsrc = bclk_mst ? gen_bclk : bstable_reg;
  wire wsrc = wclk_mst ? gen_wclk : wstable_reg;

  // Edge detection on the chosen clock sources
  logic bprev_reg;
  logic wprev_reg;
  wire  bchg      = (bsrc != bprev_reg);
  wire  launch_ev = bchg & (bsrc == launch_lvl);
  wire  sample_ev = bchg & (bsrc != launch_lvl);
  wire  wrise     = wsrc & ~wprev_reg;
  wire  wfall     = ~wsrc & wprev_reg;
  wire  wedge     = frame_md ? wrise : (wrise | wfall);

  // Framing state
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          half_b_reg;
  logic          half_b_next;
  logic          pend_reg;
  logic [CW-1:0] half_len_reg;

  // A word clock edge seen before its launch edge is held until that edge
  wire start_now = launch_ev & (pend_reg | wedge);
  wire cnt_max   = (cnt_reg == {CW{1'b1}});

  assign cnt_next    = start_now ? '0 :
                       (launch_ev & ~cnt_max) ? cnt_reg + 1'b1 : cnt_reg;
  // In I2S the left half follows the falling edge, otherwise the rising one
  assign half_b_next = (start_now & ~frame_md) ? (is_i2s ? wsrc : ~wsrc) :
                       (start_now ? 1'b0 : half_b_reg);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bprev_reg    <= 1'b0;
      wprev_reg    <= 1'b0;
      cnt_reg      <= {CW{1'b1}};
      half_b_reg   <= 1'b0;
      pend_reg     <= 1'b0;
      half_len_reg <= '0;
    end
    else
    begin
      bprev_reg    <= bsrc;
      wprev_reg    <= wsrc;
      cnt_reg      <= cnt_next;
      half_b_reg   <= half_b_next;
      pend_reg     <= launch_ev ? 1'b0 : (pend_reg | wedge);
      half_len_reg <= start_now ? cnt_reg + 1'b1 : half_len_reg;
    end
  end

  // Slot positions, counted in launch edges after frame start
  wire [CW-1:0] w_ext   = CW'(width);
  wire [CW-1:0] rjf_st  = (half_len_reg > w_ext) ? half_len_reg - w_ext : '0;
  wire [CW-1:0] lj_st   = CW'(off1_reg) + CW'(is_i2s);
  wire [CW-1:0] start_a = (is_rjf & ~frame_md) ? rjf_st : lj_st;
  wire [CW-1:0] gap_b   = tslot ? CW'(off2_reg) : '0;
  wire [CW-1:0] start_b = start_a + w_ext + gap_b;
  wire          in_a    = (cnt_next >= start_a) & (cnt_next < start_a + w_ext);
  wire          in_b    = (cnt_next >= start_b) & (cnt_next < start_b + w_ext);
  wire          act_a   = frame_md ? in_a : (in_a & ~half_b_next);
  wire          act_b   = frame_md ? in_b : (in_a & half_b_next);
  wire [CW-1:0] rel     = (frame_md & act_b) ? cnt_next - start_b : cnt_next - start_a;
  wire [4:0]    bit_idx = rel[4:0];
  wire          drive   = (act_a & en_a) | (act_b & en_b);
  wire          is_lsb  = (rel == w_ext - 1'b1);

  // Sample words; a new pair is taken at the start of the first slot's frame
  acsdp_stream_if #(.WIDTH(2 * SW)) smp_q ();

  acsdp_fifo #(
    .WIDTH (2 * SW),
    .DEPTH (ACSDP_FIFO_D)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .in_valid_i (smp_valid_i),
    .in_ready_o (smp_ready_o),
    .in_data_i  ({smp_left_i, smp_right_i}),
    .out        (smp_q.src)
  );

  logic [2*SW-1:0] pair_reg;
  wire             load_now  = start_now & ~half_b_next;
  // An empty FIFO sends silence rather than repeating the last sample
  wire  [2*SW-1:0] pair_new  = smp_q.valid ? smp_q.data : '0;
  wire  [2*SW-1:0] pair_use  = load_now ? pair_new : pair_reg;
  wire  [SW-1:0]   left_w    = pair_use[2*SW-1:SW];
  wire  [SW-1:0]   right_w   = pair_use[SW-1:0];
  wire  [SW-1:0]   word_a    = swap ? right_w : left_w;
  wire  [SW-1:0]   word_b    = swap ? left_w : right_w;
  wire  [SW-1:0]   word_cur  = act_b ? word_b : word_a;
  wire             data_bit  = word_cur[5'(SW - 1) - bit_idx];

  assign smp_q.ready = load_now;

  always_ff @(posedge mclk_i)
  begin
    pair_reg <= rst_i ? '0 : pair_use;
  end

  // Serial data drive
  logic dout_reg;
  logic doe_reg;
  logic lsb_reg;
  wire  early_cut = sample_ev & early & tri_en & lsb_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i | ~port_power_i)
    begin
      dout_reg <= 1'b0;
      doe_reg  <= 1'b0;
      lsb_reg  <= 1'b0;
    end
    else if (launch_ev)
    begin
      dout_reg <= drive & data_bit;
      doe_reg  <= drive | ~tri_en;
      lsb_reg  <= drive & is_lsb;
    end
    else if (early_cut)
    begin
      doe_reg  <= 1'b0;
      lsb_reg  <= 1'b0;
    end
  end

  // Filter sync follows the earlier enabled channel
  wire sync_a   = frame_md ? (cnt_next == start_a) : (~half_b_next & (cnt_next == start_a));
  wire sync_b   = frame_md ? (cnt_next == start_b) : (half_b_next & (cnt_next == start_a));
  wire sync_hit = launch_ev & (en_a ? sync_a : (en_b ? sync_b : (start_now & ~half_b_next)));
  logic sync_reg;

  always_ff @(posedge mclk_i)
  begin
    sync_reg <= rst_i ? 1'b0 : sync_hit;
  end
  assign filter_sync_o = sync_reg;

  // Pin drive, with output enables for the selected host only
  logic [ACSDP_HOSTS-1:0] bclk_reg;
  logic [ACSDP_HOSTS-1:0] boe_reg;
  logic [ACSDP_HOSTS-1:0] wclk_reg;
  logic [ACSDP_HOSTS-1:0] woe_reg;
  logic [ACSDP_HOSTS-1:0] dpin_reg;
  logic [ACSDP_HOSTS-1:0] dpoe_reg;

  genvar h;
  generate
    for (h = 0; h < ACSDP_HOSTS; h = h + 1)
    begin : g_host
      wire sel = (hidx == HB'(h));
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
        begin
          bclk_reg[h] <= 1'b0;
          boe_reg[h]  <= 1'b0;
          wclk_reg[h] <= 1'b0;
          woe_reg[h]  <= 1'b0;
          dpin_reg[h] <= 1'b0;
          dpoe_reg[h] <= 1'b0;
        end
        else
        begin
          bclk_reg[h] <= gen_bclk;
          boe_reg[h]  <= sel & bclk_mst & port_power_i;
          wclk_reg[h] <= gen_wclk;
          woe_reg[h]  <= sel & wclk_mst & port_power_i;
          dpin_reg[h] <= dout_reg;
          dpoe_reg[h] <= sel & doe_reg;
        end
      end
    end
  endgenerate

  assign bclk_o    = bclk_reg;
  assign bclk_oe_o = boe_reg;
  assign wclk_o    = wclk_reg;
  assign wclk_oe_o = woe_reg;
  assign dout_o    = dpin_reg;
  assign dout_oe_o = dpoe_reg;

endmodule
`default_nettype wire

/* testbench/acsdp_host_model.sv */
// Host receiver: takes the device clocks and collects each channel word
`timescale 1ns/1ps
`default_nettype none
module acsdp_host_model #(
  parameter int WBITS = 16
) (
  // Pins as seen by the host
  input  wire logic        mclk_i,
  input  wire logic        bclk_i,
  input  wire logic        wclk_i,
  input  wire logic        dout_i,
  // Captured word
  output logic [31:0]      word_o,
  output logic             left_o,
  output logic             got_o
);
  logic        bclk_reg;
  logic        wclk_reg;
  logic [5:0]  cnt_reg;
  logic [31:0] sh_reg;
  wire logic   [31:0] sh_next = {sh_reg[30:0], dout_i};
  always_ff @(posedge mclk_i)
  begin
    bclk_reg <= bclk_i;
    wclk_reg <= wclk_i;
    got_o    <= 1'b0;
    if (wclk_i != wclk_reg)
    begin
      cnt_reg <= 6'h00;
      sh_reg  <= 32'h0;
    end
    else if (bclk_i && !bclk_reg && cnt_reg < WBITS)
    begin
      sh_reg  <= sh_next;
      cnt_reg <= cnt_reg + 6'h01;
      got_o   <= cnt_reg == WBITS - 1;
      word_o  <= sh_next;
      left_o  <= wclk_i;
    end
  end
endmodule
`default_nettype wire

/* testbench/acsdp_top_assertions.sv */
// Port-level assertions for the audio serial data port
`timescale 1ns/1ps
`default_nettype none
module acsdp_top_assertions
  import acsdp_pkg::*;
#(
  parameter int BCLK_HALF = 2
) (
  // Clock, reset, registers
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Power and pins
  input wire logic       port_power_i,
  input wire logic       adc_power_i,
  input wire logic [1:0] bclk_o,
  input wire logic [1:0] bclk_oe_o,
  input wire logic [1:0] wclk_oe_o,
  input wire logic [1:0] dout_oe_o,
  input wire logic       filter_sync_o
);
  logic [7:0] fmt_reg;
  logic [7:0] pol_reg;
  logic [2:0] quiet_reg;
  wire logic  fmt_hit_w = reg_wr_i && reg_addr_i == ACSDP_FMT_ADDR;
  wire logic  pol_hit_w = reg_wr_i && reg_addr_i == ACSDP_POL_ADDR;
  wire logic  quiet_w   = quiet_reg == 3'h7;
  wire logic  mapped_w  = reg_addr_i inside {ACSDP_FMT_ADDR, ACSDP_OFF1_ADDR, ACSDP_POL_ADDR,
                                             ACSDP_DIV_ADDR, ACSDP_OFF2_ADDR, ACSDP_SLOT_ADDR};
  wire logic  [1:0] idle_host_w = pol_reg[ACSDP_HOST_BIT] ? 2'b01 : 2'b10;
  // Pin checks other than AST_PWR_OFF and AST_SYNC_PULSE wait until the configuration has been still for a while, so
  // the output pipeline depth does not matter
  always_ff @(posedge mclk_i)
  begin
    fmt_reg   <= rst_i ? ACSDP_REG_RST : (fmt_hit_w ? reg_wdata_i : fmt_reg);
    pol_reg   <= rst_i ? ACSDP_REG_RST : (pol_hit_w ? reg_wdata_i : pol_reg);
    quiet_reg <= (rst_i || reg_wr_i || $changed(adc_power_i) || $changed(port_power_i)) ? 3'h0
                 : (quiet_w ? quiet_reg : quiet_reg + 3'h1);
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_write;
    reg_wr_i && mapped_w;
  endsequence
  sequence s_reread;
    $stable(reg_addr_i) && !reg_wr_i;
  endsequence
  AST_READBACK: assert property (s_write ##1 s_reread |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("register read back differs from written value");
  AST_UNMAPPED: assert property (!mapped_w |=> reg_rdata_o == 8'h00)
    else $error("unmapped offset read nonzero");
  AST_PWR_OFF: assert property (
    !port_power_i [*3] |-> (bclk_oe_o | wclk_oe_o | dout_oe_o) == 2'b00)
    else $error("pins driven while port powered down");
  AST_SYNC_PULSE: assert property (filter_sync_o |=> !filter_sync_o)
    else $error("filter sync longer than one cycle");
  AST_BCLK_SLAVE: assert property (quiet_w && !fmt_reg[ACSDP_BMST_BIT] |-> bclk_oe_o == 2'b00)
    else $error("bit clock driven in slave mode");
  AST_WCLK_SLAVE: assert property (quiet_w && !fmt_reg[ACSDP_WMST_BIT] |-> wclk_oe_o == 2'b00)
    else $error("word clock driven in slave mode");
  AST_CLK_STOP: assert property (
    quiet_w && fmt_reg[ACSDP_BMST_BIT] && !adc_power_i && !pol_reg[ACSDP_KEEP_BIT]
    |-> bclk_o == 2'b00)
    else $error("master bit clock runs without converter power");
  AST_ONE_HOST: assert property (
    quiet_w |-> ((bclk_oe_o | wclk_oe_o | dout_oe_o) & idle_host_w) == 2'b00)
    else $error("unselected host pins driven");
  AST_DATA_ZERO: assert property (
    quiet_w && port_power_i && !fmt_reg[ACSDP_TRI_BIT] |-> dout_oe_o[pol_reg[ACSDP_HOST_BIT]])
    else $error("data line released with tristate off");
endmodule
`default_nettype wire

/* testbench/acsdp_top_tb.sv */
// Testbench: registers, FIFO fill, left aligned master framing, power down
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) compares++; if ((s) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end
module acsdp_top_tb;
  import acsdp_pkg::*;
  localparam logic [31:0] LEFT  = 32'ha5c3_1234;
  localparam logic [31:0] RIGHT = 32'h3c5a_5678;
  logic        mclk_i, rst_i, reg_wr_i, port_power_i, adc_power_i, smp_valid_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic        smp_ready_o, filter_sync_o, got_w, left_w;
  logic [1:0]  bclk_o, bclk_oe_o, wclk_o, wclk_oe_o, dout_o, dout_oe_o;
  logic [31:0] word_w, w;
  int          compares, miscompares, n;
  acsdp_top #(.BCLK_HALF(2)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .port_power_i(port_power_i), .adc_power_i(adc_power_i), .smp_valid_i(smp_valid_i),
    .smp_ready_o(smp_ready_o), .smp_left_i(LEFT), .smp_right_i(RIGHT), .bclk_i(2'b00),
    .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o), .wclk_i(2'b00), .wclk_o(wclk_o),
    .wclk_oe_o(wclk_oe_o), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .filter_sync_o(filter_sync_o));
  // Released pins read low, as with pull-downs on the host board
  acsdp_host_model #(.WBITS(16)) host_u (.mclk_i(mclk_i), .bclk_i(bclk_oe_o[0] & bclk_o[0]),
    .wclk_i(wclk_oe_o[0] & wclk_o[0]), .dout_i(dout_oe_o[0] & dout_o[0]),
    .word_o(word_w), .left_o(left_w), .got_o(got_w));
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    reg_addr_i = a;
    @(negedge mclk_i);
    `CHK("register", e, reg_rdata_o)
  endtask
  // First word seen is skipped, as it may belong to a frame cut by setup
  task automatic get_word(input logic l);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      while (!(got_w === 1'b1 && left_w === l) && n < 9000)
      begin
        @(negedge mclk_i);
        n++;
      end
      if (n == 9000) begin miscompares++; give_verdict(); end
      @(negedge mclk_i);
    end
    w = word_w;
  endtask
  task automatic t_regs();
    logic [7:0] a [6] = '{ACSDP_FMT_ADDR, ACSDP_OFF1_ADDR, ACSDP_POL_ADDR,
                          ACSDP_DIV_ADDR, ACSDP_OFF2_ADDR, ACSDP_SLOT_ADDR};
    for (int i = 0; i < 6; i++) rd(a[i], ACSDP_REG_RST);
    for (int i = 0; i < 6; i++) begin wr(a[i], 8'h5a ^ i[7:0]); rd(a[i], 8'h5a ^ i[7:0]); end
    rd(8'h20, 8'h00);
  endtask
  // No frames run while powered down, so the FIFO must refuse after four
  task automatic t_fifo();
    smp_valid_i = 1'b1;
    n = 0;
    repeat (12) begin n += (smp_ready_o === 1'b1); @(negedge mclk_i); end
    `CHK("pairs taken", 4, n)
  endtask
  task automatic t_frames();
    wr(ACSDP_FMT_ADDR, 8'hcc);
    wr(ACSDP_OFF1_ADDR, 8'h00);
    wr(ACSDP_POL_ADDR, 8'h00);
    wr(ACSDP_DIV_ADDR, 8'h40);
    wr(ACSDP_SLOT_ADDR, 8'h00);
    port_power_i = 1'b1;
    adc_power_i  = 1'b1;
    get_word(1'b1);
    `CHK("left word", {16'h0, LEFT[31:16]}, w)
    get_word(1'b0);
    `CHK("right word", {16'h0, RIGHT[31:16]}, w)
    wr(ACSDP_SLOT_ADDR, 8'h10);
    get_word(1'b1);
    `CHK("swapped first word", {16'h0, RIGHT[31:16]}, w)
    wr(ACSDP_SLOT_ADDR, 8'h00);
    wr(ACSDP_OFF1_ADDR, 8'h01);
    get_word(1'b1);
    `CHK("offset word", {17'h0, LEFT[31:17]}, w)
    wr(ACSDP_OFF1_ADDR, 8'h00);
    wr(ACSDP_FMT_ADDR, 8'h0c);
    get_word(1'b0);
    `CHK("i2s left word", {17'h0, LEFT[31:17]}, w)
  endtask
  task automatic t_power();
    adc_power_i = 1'b0;
    repeat (40) @(negedge mclk_i);
    `CHK("stopped bit clock", 2'b00, bclk_o)
    port_power_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    `CHK("pin enables", 6'h00, {bclk_oe_o, wclk_oe_o, dout_oe_o})
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial
  begin
    {rst_i, reg_wr_i, port_power_i, adc_power_i, smp_valid_i} = 5'b10000;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    t_regs();
    t_fifo();
    t_frames();
    t_power();
    give_verdict();
  end
endmodule
bind acsdp_top acsdp_top_assertions #(.BCLK_HALF(BCLK_HALF)) chk_u (.mclk_i(mclk_i),
  .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .port_power_i(port_power_i), .adc_power_i(adc_power_i),
  .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o), .wclk_oe_o(wclk_oe_o), .dout_oe_o(dout_oe_o),
  .filter_sync_o(filter_sync_o));
`default_nettype wire
